// ### logic/converter_output_clock_config.sv
// register bank for output format, clock phase, clock delay and sync control
`timescale 1ns/1ps
`default_nettype none
module converter_output_clock_config (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] self_test_sig,
  input wire logic self_test_sig_valid,
  input wire logic sync_pin,
  output logic drive_reduced,
  output logic output_differential,
  output logic output_enable_n,
  output logic output_invert,
  output logic [1:0] number_format,
  output logic [2:0] divider_phase_adjust,
  output logic output_data_clock_invert,
  output logic [4:0] output_data_clock_delay,
  output logic [11:0] output_data_clock_delay_ps,
  output logic [1:0] reference_level,
  output logic noise_injection_enable,
  output logic divider_sync_pulse
);
  typedef struct packed {
    logic [7:0] out_fmt;
    logic [7:0] clk_phase;
    logic [7:0] clk_delay;
    logic [7:0] ref_sel;
    logic [7:0] dither;
    logic [7:0] sync_ctl;
    logic [15:0] sig;
    logic [7:0] rdata;
    logic [11:0] delay_ps;
  } bank_s;
  bank_s st_reg, st_next;
  logic div_sync;
  logic auto_clear;
  logic [7:0] rd_mux;
  logic [16:0] prod;

  sync_pulse_gate sync_pulse_gate_i (
    .clk(clk),
    .rst(rst),
    .sync_pin(sync_pin),
    .master_en(st_reg.sync_ctl[conv_cfg_pkg::BIT_MASTER]),
    .div_en(st_reg.sync_ctl[conv_cfg_pkg::BIT_DIV_EN]),
    .next_only(st_reg.sync_ctl[conv_cfg_pkg::BIT_NEXT_ONLY]),
    .div_sync(div_sync),
    .auto_clear(auto_clear)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    rd_mux = 8'h00;
    case (reg_addr)
      conv_cfg_pkg::ADDR_OUT_FMT: rd_mux = st_reg.out_fmt;
      conv_cfg_pkg::ADDR_CLK_PHASE: rd_mux = st_reg.clk_phase;
      conv_cfg_pkg::ADDR_CLK_DELAY: rd_mux = st_reg.clk_delay;
      conv_cfg_pkg::ADDR_REF_SEL: rd_mux = st_reg.ref_sel;
      conv_cfg_pkg::ADDR_SIG_LO: rd_mux = st_reg.sig[7:0];
      conv_cfg_pkg::ADDR_SIG_HI: rd_mux = st_reg.sig[15:8];
      conv_cfg_pkg::ADDR_DITHER: rd_mux = st_reg.dither;
      conv_cfg_pkg::ADDR_SYNC: rd_mux = st_reg.sync_ctl;
      default: rd_mux = 8'h00;
    endcase
    if (reg_rd) begin
      st_next.rdata = rd_mux;
    end
    if (self_test_sig_valid) begin
      st_next.sig = self_test_sig;
    end
    if (reg_wr) begin
      case (reg_addr)
        conv_cfg_pkg::ADDR_OUT_FMT: begin
          st_next.out_fmt = reg_wdata & conv_cfg_pkg::MASK_OUT_FMT;
        end
        conv_cfg_pkg::ADDR_CLK_PHASE: begin
          st_next.clk_phase = reg_wdata & conv_cfg_pkg::MASK_CLK_PHASE;
        end
        conv_cfg_pkg::ADDR_CLK_DELAY: begin
          st_next.clk_delay = reg_wdata & conv_cfg_pkg::MASK_CLK_DELAY;
        end
        conv_cfg_pkg::ADDR_REF_SEL: begin
          st_next.ref_sel = reg_wdata & conv_cfg_pkg::MASK_REF_SEL;
        end
        conv_cfg_pkg::ADDR_DITHER: begin
          st_next.dither = reg_wdata & conv_cfg_pkg::MASK_DITHER;
        end
        conv_cfg_pkg::ADDR_SYNC: begin
          st_next.sync_ctl = reg_wdata & conv_cfg_pkg::MASK_SYNC;
        end
        default: st_next.sync_ctl = st_next.sync_ctl;
      endcase
    end
    // self clear wins over a simultaneous write: the sync already happened
    if (auto_clear) begin
      st_next.sync_ctl[conv_cfg_pkg::BIT_DIV_EN] = 1'b0;
    end
    // nearest integer ps; the divisor is odd, so no ties to break
    prod = 17'(st_next.clk_delay[4:0]) * 17'(conv_cfg_pkg::DELAY_FULL_PS)
      + 17'(conv_cfg_pkg::DELAY_STEPS / 2);
    st_next.delay_ps = 12'(prod / 17'(conv_cfg_pkg::DELAY_STEPS));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg.out_fmt <= conv_cfg_pkg::RST_OUT_FMT;
      st_reg.clk_phase <= conv_cfg_pkg::RST_CLK_PHASE;
      st_reg.clk_delay <= conv_cfg_pkg::RST_CLK_DELAY;
      st_reg.ref_sel <= conv_cfg_pkg::RST_REF_SEL;
      st_reg.dither <= conv_cfg_pkg::RST_DITHER;
      st_reg.sync_ctl <= conv_cfg_pkg::RST_SYNC;
      st_reg.sig <= conv_cfg_pkg::RST_SIG;
      st_reg.rdata <= 8'h00;
      st_reg.delay_ps <= 12'h000;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = st_reg.rdata;
  assign drive_reduced = st_reg.out_fmt[conv_cfg_pkg::BIT_DRIVE];
  assign output_differential = st_reg.out_fmt[conv_cfg_pkg::BIT_TYPE];
  assign output_enable_n = st_reg.out_fmt[conv_cfg_pkg::BIT_OE_N];
  assign output_invert = st_reg.out_fmt[conv_cfg_pkg::BIT_INVERT];
  // code 10 is gray, 11 passed through as reserved
  assign number_format = st_reg.out_fmt[1:0];
  assign divider_phase_adjust = st_reg.clk_phase[2:0];
  assign output_data_clock_invert = st_reg.clk_phase[conv_cfg_pkg::BIT_CLK_INV];
  assign output_data_clock_delay = st_reg.clk_delay[4:0];
  assign output_data_clock_delay_ps = st_reg.delay_ps;
  assign reference_level = st_reg.ref_sel[7:6];
  assign noise_injection_enable = st_reg.dither[conv_cfg_pkg::BIT_DITHER];
  assign divider_sync_pulse = div_sync;

  ////////////////////////////////////////////////////////////////////////////
  a_fmt_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> number_format == 2'h0 && output_enable_n == 1'b0)
    else $error("format not zero after reset");
  a_reset_bank: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> st_reg.out_fmt == conv_cfg_pkg::RST_OUT_FMT
      && st_reg.clk_phase == conv_cfg_pkg::RST_CLK_PHASE
      && st_reg.clk_delay == conv_cfg_pkg::RST_CLK_DELAY
      && st_reg.ref_sel == conv_cfg_pkg::RST_REF_SEL
      && st_reg.dither == conv_cfg_pkg::RST_DITHER
      && st_reg.sync_ctl == conv_cfg_pkg::RST_SYNC
      && st_reg.sig == conv_cfg_pkg::RST_SIG)
    else $error("bank not at reset values");
  a_fmt_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_OUT_FMT) |=>
    number_format == $past(reg_wdata[1:0])) else $error("format write lost");
  a_mode_bits: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_OUT_FMT) |=>
    output_enable_n == $past(reg_wdata[conv_cfg_pkg::BIT_OE_N])
      && drive_reduced == $past(reg_wdata[conv_cfg_pkg::BIT_DRIVE])
      && output_differential == $past(reg_wdata[conv_cfg_pkg::BIT_TYPE])
      && output_invert == $past(reg_wdata[conv_cfg_pkg::BIT_INVERT]))
    else $error("output mode bits lost");
  // a same-cycle write must not leak into the read path
  a_rd_old: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_wr && reg_addr == conv_cfg_pkg::ADDR_OUT_FMT) |=>
    reg_rdata == $past(st_reg.out_fmt)) else $error("read showed new value");
  a_bank_masked: assert property (@(posedge clk) disable iff (rst)
    (st_reg.out_fmt & ~conv_cfg_pkg::MASK_OUT_FMT) == 8'h00
      && (st_reg.clk_phase & ~conv_cfg_pkg::MASK_CLK_PHASE) == 8'h00
      && (st_reg.clk_delay & ~conv_cfg_pkg::MASK_CLK_DELAY) == 8'h00
      && (st_reg.sync_ctl & ~conv_cfg_pkg::MASK_SYNC) == 8'h00)
    else $error("reserved bits set");
  a_phase_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_CLK_PHASE) |=>
    divider_phase_adjust == $past(reg_wdata[2:0])
      && output_data_clock_invert == $past(reg_wdata[conv_cfg_pkg::BIT_CLK_INV]))
    else $error("phase write lost");
  a_phase_hold: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && reg_addr == conv_cfg_pkg::ADDR_CLK_PHASE) |=> $stable(divider_phase_adjust))
    else $error("phase changed without write");
  a_delay_full: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_CLK_DELAY && reg_wdata[4:0] == 5'h1f) |=>
    output_data_clock_delay_ps == 12'h9c4) else $error("full delay not 2500 ps");
  a_delay_zero: assert property (@(posedge clk) disable iff (rst)
    output_data_clock_delay == 5'h00 |-> output_data_clock_delay_ps == 12'h000)
    else $error("zero code gives delay");
  // fixed points of the delay line: truncation would give 80 ps for code one
  a_delay_one: assert property (@(posedge clk) disable iff (rst)
    output_data_clock_delay == 5'h01 |-> output_data_clock_delay_ps == 12'h051)
    else $error("code one not 81 ps");
  a_delay_two: assert property (@(posedge clk) disable iff (rst)
    output_data_clock_delay == 5'h02 |-> output_data_clock_delay_ps == 12'h0a1)
    else $error("code two not 161 ps");
  a_delay_thirty: assert property (@(posedge clk) disable iff (rst)
    output_data_clock_delay == 5'h1e |-> output_data_clock_delay_ps == 12'h973)
    else $error("code thirty not 2419 ps");
  a_ref_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_REF_SEL) |=>
    reference_level == $past(reg_wdata[7:6])) else $error("reference write lost");
  a_dither_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_DITHER) |=>
    noise_injection_enable == $past(reg_wdata[conv_cfg_pkg::BIT_DITHER]))
    else $error("dither write lost");
  a_sig_capture: assert property (@(posedge clk) disable iff (rst)
    self_test_sig_valid |=> st_reg.sig == $past(self_test_sig))
    else $error("signature not captured");
  a_sig_read_lo: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == conv_cfg_pkg::ADDR_SIG_LO) |=> reg_rdata == $past(st_reg.sig[7:0]))
    else $error("signature low byte wrong");
  a_sig_read_hi: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == conv_cfg_pkg::ADDR_SIG_HI) |=> reg_rdata == $past(st_reg.sig[15:8]))
    else $error("signature high byte wrong");
  a_sig_ro: assert property (@(posedge clk) disable iff (rst)
    (!self_test_sig_valid) |=> st_reg.sig == $past(st_reg.sig))
    else $error("signature changed by write");
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data not held");
  a_gray_code: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == conv_cfg_pkg::ADDR_OUT_FMT && reg_wdata[1:0] == conv_cfg_pkg::FMT_GRAY)
    |=> number_format == conv_cfg_pkg::FMT_GRAY) else $error("gray code not held");
  a_master_gate: assert property (@(posedge clk) disable iff (rst)
    !st_reg.sync_ctl[0] [*3] |-> !divider_sync_pulse) else $error("sync without master");
  a_div_gate: assert property (@(posedge clk) disable iff (rst)
    !st_reg.sync_ctl[conv_cfg_pkg::BIT_DIV_EN] [*2] |-> !divider_sync_pulse)
    else $error("sync passed with divider enable clear");
  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    divider_sync_pulse |=> !divider_sync_pulse) else $error("sync pulse too long");
  a_one_shot: assert property (@(posedge clk) disable iff (rst)
    auto_clear |=> !st_reg.sync_ctl[conv_cfg_pkg::BIT_DIV_EN]) else $error("enable not cleared");
  a_clr_once: assert property (@(posedge clk) disable iff (rst)
    auto_clear |=> !auto_clear) else $error("divider enable cleared twice");
  c_cont_sync: cover property (@(posedge clk) disable iff (rst)
    divider_sync_pulse ##[1:20] divider_sync_pulse);
  c_one_shot: cover property (@(posedge clk) disable iff (rst) auto_clear);
  c_sig_read: cover property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == conv_cfg_pkg::ADDR_SIG_LO);
  c_gray_sel: cover property (@(posedge clk) disable iff (rst)
    number_format == conv_cfg_pkg::FMT_GRAY);
  c_phase_max: cover property (@(posedge clk) disable iff (rst) divider_phase_adjust == 3'h7);
endmodule
`default_nettype wire

// ### logic/conv_cfg_pkg.sv
// constants for the converter output and clock configuration bank
// Functional notes
// - output mode register drives drive, type, enable_n, invert and number format; resets zero.
// - phase field delays divider clock by coded input cycles; bit 7 inverts output clock.
// - output clock delay is 2500 ps times five-bit code over 31.
// - self-test signature readable as low and high bytes; both zero after reset.
// - sync has no effect unless master sync enable bit 0 is set.
// - master and divider enables set pass every sync pulse to the divider.
// - next-sync-only passes first pulse, then divider enable clears itself.
package conv_cfg_pkg;
  localparam logic [8:0] ADDR_OUT_FMT = 9'h014;
  localparam logic [8:0] ADDR_CLK_PHASE = 9'h016;
  localparam logic [8:0] ADDR_CLK_DELAY = 9'h017;
  localparam logic [8:0] ADDR_REF_SEL = 9'h018;
  localparam logic [8:0] ADDR_SIG_LO = 9'h024;
  localparam logic [8:0] ADDR_SIG_HI = 9'h025;
  localparam logic [8:0] ADDR_DITHER = 9'h030;
  localparam logic [8:0] ADDR_SYNC = 9'h100;
  localparam logic [7:0] RST_OUT_FMT = 8'h00;
  localparam logic [7:0] RST_CLK_PHASE = 8'h00;
  localparam logic [7:0] RST_CLK_DELAY = 8'h00;
  localparam logic [7:0] RST_REF_SEL = 8'hc0;
  localparam logic [7:0] RST_DITHER = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [15:0] RST_SIG = 16'h0000;
  localparam logic [7:0] MASK_OUT_FMT = 8'hd7;
  localparam logic [7:0] MASK_CLK_PHASE = 8'h87;
  localparam logic [7:0] MASK_CLK_DELAY = 8'h1f;
  localparam logic [7:0] MASK_REF_SEL = 8'hc0;
  localparam logic [7:0] MASK_DITHER = 8'h10;
  localparam logic [7:0] MASK_SYNC = 8'h07;
  localparam int BIT_DRIVE = 7;
  localparam int BIT_TYPE = 6;
  localparam int BIT_OE_N = 4;
  localparam int BIT_INVERT = 2;
  localparam int BIT_CLK_INV = 7;
  localparam int BIT_DITHER = 4;
  localparam int BIT_MASTER = 0;
  localparam int BIT_DIV_EN = 1;
  localparam int BIT_NEXT_ONLY = 2;
  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
  localparam int DELAY_FULL_PS = 2500;
  localparam int DELAY_STEPS = 31;
  typedef enum logic [1:0] {FMT_SEL_OFFSET, FMT_SEL_TWOS, FMT_SEL_GRAY, FMT_SEL_RSVD} fmt_sel_e;
endpackage

// ### logic/sync_pulse_gate.sv
// sync pulse gating toward the clock divider
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_pin,
  input wire logic master_en,
  input wire logic div_en,
  input wire logic next_only,
  output logic div_sync,
  output logic auto_clear
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
    logic clr;
  } gate_s;
  gate_s st_reg, st_next;
  logic rise;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = sync_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    rise = st_reg.s2 & ~st_reg.s3;
    st_next.pulse = rise & master_en & div_en;
    st_next.clr = rise & master_en & div_en & next_only;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign div_sync = st_reg.pulse;
  assign auto_clear = st_reg.clr;
  a_sync_gated: assert property (@(posedge clk) disable iff (rst)
    div_sync |-> $past(master_en)) else $error("sync passed without master enable");
  a_sync_pass: assert property (@(posedge clk) disable iff (rst)
    (rise && master_en && div_en) |=> div_sync) else $error("sync pulse lost");
endmodule
`default_nettype wire

// ### testbench/cfg_host.sv
// register host model that issues writes and reads to the configuration bank
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input wire logic clk,
  output logic [8:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 9'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // called on a rising edge; returns one edge after the strobe is dropped
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released data shows the inverse, never a stale copy
    reg_wdata <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_converter_output_clock_config.sv
// self-checking bench for the converter output and clock configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_converter_output_clock_config;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] reg_addr;
  logic reg_wr, reg_rd, self_test_sig_valid, output_data_clock_invert;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [15:0] self_test_sig = 16'h0000;
  logic sync_pin = 1'b0;
  logic drive_reduced, output_differential, output_enable_n, output_invert;
  logic noise_injection_enable, divider_sync_pulse;
  logic [1:0] number_format, reference_level;
  logic [2:0] divider_phase_adjust;
  logic [4:0] output_data_clock_delay;
  logic [11:0] output_data_clock_delay_ps;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  initial self_test_sig_valid = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) if (divider_sync_pulse === 1'b1) pulses <= pulses + 1;
  cfg_host cfg_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  converter_output_clock_config converter_output_clock_config_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .self_test_sig(self_test_sig),
    .self_test_sig_valid(self_test_sig_valid), .sync_pin(sync_pin),
    .drive_reduced(drive_reduced), .output_differential(output_differential),
    .output_enable_n(output_enable_n), .output_invert(output_invert),
    .number_format(number_format), .divider_phase_adjust(divider_phase_adjust),
    .output_data_clock_invert(output_data_clock_invert),
    .output_data_clock_delay(output_data_clock_delay),
    .output_data_clock_delay_ps(output_data_clock_delay_ps),
    .reference_level(reference_level), .noise_injection_enable(noise_injection_enable),
    .divider_sync_pulse(divider_sync_pulse));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    cfg_host_i.rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask
  task automatic sync_pulse();
    sync_pin <= 1'b1;
    repeat (2) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [8:0] adr [9] = '{9'h014, 9'h016, 9'h017, 9'h018, 9'h024, 9'h025, 9'h030,
      9'h100, 9'h0ff};
    logic [7:0] exp [9] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    chk({10'h0, drive_reduced, output_differential, output_enable_n, output_invert,
      number_format}, 16'h0000);
    chk({3'h0, divider_phase_adjust, output_data_clock_invert, output_data_clock_delay,
      reference_level, noise_injection_enable, divider_sync_pulse}, 16'h000c);
    chk({4'h0, output_data_clock_delay_ps}, 16'h0000);
    for (int i = 0; i < 9; i++) rd_chk(adr[i], exp[i]);
  endtask
  task automatic t_fmt();
    logic [7:0] bit_wr [4] = '{8'h80, 8'h40, 8'h10, 8'h04};
    logic [5:0] bit_out [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    for (int b = 0; b < 4; b++) begin
      cfg_host_i.wr(9'h014, bit_wr[b]);
      chk({10'h0, drive_reduced, output_differential, output_enable_n, output_invert,
        number_format}, {10'h0, bit_out[b]});
    end
    cfg_host_i.wr(9'h014, 8'hff);
    chk({10'h0, drive_reduced, output_differential, output_enable_n, output_invert,
      number_format}, 16'h003f);
    rd_chk(9'h014, 8'hd7);
    for (int f = 0; f < 4; f++) begin
      cfg_host_i.wr(9'h014, 8'h00 | f[1:0]);
      chk({13'h0, output_invert, number_format}, {14'h0, f[1:0]});
    end
    cfg_host_i.wr(9'h018, 8'h7f);
    rd_chk(9'h018, 8'h40);
    chk({14'h0, reference_level}, 16'h0001);
    cfg_host_i.wr(9'h030, 8'hff);
    chk({15'h0, noise_injection_enable}, 16'h0001);
  endtask
  task automatic t_clk();
    for (int c = 0; c < 8; c++) begin
      cfg_host_i.wr(9'h016, {c[0], 4'h0, c[2:0]});
      chk({12'h0, output_data_clock_invert, divider_phase_adjust}, {12'h0, c[0], c[2:0]});
    end
    // reserved upper bits set on purpose, they must read back clear
    for (int c = 0; c < 32; c++) begin
      cfg_host_i.wr(9'h017, {3'h7, c[4:0]});
      chk({11'h0, output_data_clock_delay}, {11'h0, c[4:0]});
      chk({4'h0, output_data_clock_delay_ps}, 16'((c * 2500 + 15) / 31));
    end
    rd_chk(9'h017, 8'h1f);
  endtask
  task automatic t_sig();
    self_test_sig <= 16'hc35a;
    self_test_sig_valid <= 1'b1;
    @(posedge clk);
    self_test_sig_valid <= 1'b0;
    self_test_sig <= 16'h3ca5;
    @(posedge clk);
    cfg_host_i.wr(9'h024, 8'hff);
    rd_chk(9'h024, 8'h5a);
    rd_chk(9'h025, 8'hc3);
  endtask
  task automatic t_sync();
    int base;
    // counter has one driver; each step is judged against a snapshot
    base = pulses;
    cfg_host_i.wr(9'h100, 8'h06);
    sync_pulse();
    chk(16'(pulses - base), 16'h0000);
    cfg_host_i.wr(9'h100, 8'h03);
    sync_pulse();
    sync_pulse();
    chk(16'(pulses - base), 16'h0002);
    base = pulses;
    cfg_host_i.wr(9'h100, 8'h07);
    sync_pulse();
    sync_pulse();
    chk(16'(pulses - base), 16'h0001);
    rd_chk(9'h100, 8'h05);
  endtask
  task automatic t_rerst();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    $display("reset test done");
    t_fmt();
    $display("format test done");
    t_clk();
    $display("clock test done");
    t_sig();
    $display("signature test done");
    t_sync();
    $display("sync test done");
    t_rerst();
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire
